/* File: inc/srr_pkg.sv */
// Shared constants and types for the standard request responder
package srr_pkg;
   // Request type codes
   localparam logic [7:0] RT_DEV_OUT = 8'h00;
   localparam logic [7:0] RT_IF_OUT = 8'h01;
   localparam logic [7:0] RT_EP_OUT = 8'h02;
   localparam logic [7:0] RT_DEV_IN = 8'h80;
   localparam logic [7:0] RT_IF_IN = 8'h81;
   // Request codes
   localparam logic [7:0] REQ_CLEAR_FEATURE = 8'h01;
   localparam logic [7:0] REQ_GET_DESCRIPTOR = 8'h06;
   localparam logic [7:0] REQ_GET_CONFIGURATION = 8'h08;
   localparam logic [7:0] REQ_GET_INTERFACE = 8'h0a;
   // Descriptor types
   localparam logic [7:0] DT_DEVICE = 8'h01;
   localparam logic [7:0] DT_CONFIG = 8'h02;
   localparam logic [7:0] DT_STRING = 8'h03;
   localparam logic [7:0] DT_QUALIFIER = 8'h06;
   localparam logic [7:0] DT_OTHER_SPEED = 8'h07;
   // Feature selectors
   localparam logic [15:0] FS_ENDPOINT_HALT = 16'h0000;
   localparam logic [15:0] FS_REMOTE_WAKEUP = 16'h0001;
   localparam logic [15:0] FS_TEST_MODE = 16'h0002;
   // Index field layout when it names an endpoint
   localparam int EP_NUM_LSB = 0;
   localparam int EP_NUM_W = 4;
   localparam int EP_DIR_BIT = 7;
   // Fixed lengths
   localparam logic [15:0] LEN_ONE = 16'h0001;
   localparam logic [15:0] LEN_ZERO = 16'h0000;
   // Device states
   typedef enum logic [1:0] {
      DST_DEFAULT = 2'b00,
      DST_ADDRESS = 2'b01,
      DST_CONFIGURED = 2'b10
   } srr_dstate_t;
   // Device end sequencer
   typedef enum logic [2:0] {
      DV_IDLE = 3'b000,
      DV_DECODE = 3'b001,
      DV_STREAM = 3'b010,
      DV_FLUSH = 3'b011,
      DV_CMPL = 3'b100
   } srr_dev_fsm_t;
   // Host end sequencer
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_SETUP = 2'b01,
      HS_WAIT = 2'b10
   } srr_host_fsm_t;
endpackage : srr_pkg

/* File: inc/srr_link_if.sv */
// Link between the host end and the device end of the request responder
`timescale 1ns/1ps
`default_nettype none
interface srr_link_if;
   logic setup_valid;
   logic setup_ready;
   logic [7:0] rtype;
   logic [7:0] code;
   logic [15:0] value;
   logic [15:0] index;
   logic [15:0] length;
   logic data_valid;
   logic data_ready;
   logic [7:0] data;
   logic data_last;
   logic cmpl_valid;
   logic cmpl_stall;
   logic cmpl_short;
   modport dev(
      input setup_valid, rtype, code, value, index, length, data_ready,
      output setup_ready, data_valid, data, data_last, cmpl_valid, cmpl_stall, cmpl_short
   );
   modport host(
      output setup_valid, rtype, code, value, index, length, data_ready,
      input setup_ready, data_valid, data, data_last, cmpl_valid, cmpl_stall, cmpl_short
   );
endinterface : srr_link_if
`default_nettype wire

/* File: hw/srr_device.sv */
// Device end: decodes standard requests and streams answers
`timescale 1ns/1ps
`default_nettype none
module srr_device #(
   parameter int NUM_IF = 1,
   parameter int NUM_EP = 2,
   parameter int DIR_SLOTS = 4,
   parameter int MEM_AW = 8,
   parameter int MAX_PKT = 8,
   parameter bit HS_CAPABLE = 1'b0,
   parameter bit RWAKE_SUPPORT = 1'b1
) (
   // Clock, reset, enable
   input wire logic CLOCK_I,
   input wire logic RESET_N_I,
   input wire logic CE_I,
   // Link to the host end
   srr_link_if.dev link,
   // Device state from the enumeration logic
   input wire logic DEV_ADDRESSED_I,
   input wire logic [7:0] CONFIG_VALUE_I,
   input wire logic [NUM_IF*8-1:0] ALT_SETTING_I,
   // Descriptor store load port
   input wire logic DESC_WE_I,
   input wire logic [MEM_AW-1:0] DESC_ADDR_I,
   input wire logic [7:0] DESC_DATA_I,
   // Descriptor directory load port
   input wire logic DIR_WE_I,
   input wire logic [$clog2(DIR_SLOTS)-1:0] DIR_SEL_I,
   input wire logic [7:0] DIR_TYPE_I,
   input wire logic [7:0] DIR_INDEX_I,
   input wire logic [MEM_AW-1:0] DIR_BASE_I,
   input wire logic [15:0] DIR_LEN_I,
   // Feature clear actions and state
   output logic CLR_REMOTE_WAKEUP_O,
   output logic CLR_HALT_O,
   output logic [srr_pkg::EP_NUM_W-1:0] CLR_HALT_EP_O,
   output logic CLR_HALT_IN_O,
   output logic [1:0] DEV_STATE_O
);
   localparam int SW = $clog2(DIR_SLOTS);

   generate
      // Slot select must not reach past the directory, so only powers of two
      if (NUM_IF < 1 || NUM_EP < 1 || NUM_EP > 16 || DIR_SLOTS < 2 || MAX_PKT < 1
          || (1 << SW) != DIR_SLOTS) begin : g_bad
         $error("srr_device: unsupported parameter values");
      end
   endgenerate

   srr_pkg::srr_dstate_t dstate_r;
   srr_pkg::srr_dev_fsm_t fsm_r;
   logic [7:0] cfg_r;
   logic [7:0] rt_r;
   logic [7:0] rq_r;
   logic [15:0] val_r;
   logic [15:0] idx_r;
   logic [15:0] len_r;
   logic [7:0] mem [0:(1<<MEM_AW)-1];
   logic [7:0] dir_type_r [DIR_SLOTS];
   logic [7:0] dir_idx_r [DIR_SLOTS];
   logic [MEM_AW-1:0] dir_base_r [DIR_SLOTS];
   logic [15:0] dir_len_r [DIR_SLOTS];
   logic [DIR_SLOTS-1:0] hit_vec;
   logic hit;
   logic [MEM_AW-1:0] hit_base;
   logic [15:0] hit_len;
   logic dec_err;
   logic dec_desc;
   logic dec_byte_mode;
   logic [7:0] dec_byte;
   logic clr_rw;
   logic clr_halt;
   logic ep_ok;
   logic [srr_pkg::EP_NUM_W-1:0] ep_num;
   logic [15:0] cnt_r;
   logic [MEM_AW-1:0] ptr_r;
   logic use_byte_r;
   logic [7:0] byte_r;
   logic stall_r;
   logic short_r;
   logic [8:0] buf_r [2];
   logic wp_r;
   logic rp_r;
   logic [1:0] fcnt_r;
   logic push;
   logic pop;

   // State follows the enumeration inputs in every cycle with the enable high
   always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         dstate_r <= srr_pkg::DST_DEFAULT;
         cfg_r <= 8'h00;
      end else if (CE_I) begin
         cfg_r <= CONFIG_VALUE_I;
         if (CONFIG_VALUE_I != 8'h00 && DEV_ADDRESSED_I) begin
            dstate_r <= srr_pkg::DST_CONFIGURED;
         end else if (DEV_ADDRESSED_I) begin
            dstate_r <= srr_pkg::DST_ADDRESS;
         end else begin
            dstate_r <= srr_pkg::DST_DEFAULT;
         end
      end
   end
   assign DEV_STATE_O = dstate_r;

   // Descriptor bytes carry no reset; contents are loaded before use
   always_ff @(posedge CLOCK_I) begin
      if (CE_I && DESC_WE_I) begin
         mem[DESC_ADDR_I] <= DESC_DATA_I;
      end
   end

   // Directory of stored descriptors; zero length marks an empty slot
   always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         for (int i = 0; i < DIR_SLOTS; i++) begin
            dir_type_r[i] <= 8'h00;
            dir_idx_r[i] <= 8'h00;
            dir_base_r[i] <= '0;
            dir_len_r[i] <= 16'h0000;
         end
      end else if (CE_I && DIR_WE_I) begin
         dir_type_r[DIR_SEL_I] <= DIR_TYPE_I;
         dir_idx_r[DIR_SEL_I] <= DIR_INDEX_I;
         dir_base_r[DIR_SEL_I] <= DIR_BASE_I;
         dir_len_r[DIR_SEL_I] <= DIR_LEN_I;
      end
   end

   // Type in the high byte, index in the low byte
   genvar g;
   generate
      for (g = 0; g < DIR_SLOTS; g++) begin : g_dir
         assign hit_vec[g] = (dir_len_r[g] != 16'h0000) && (dir_type_r[g] == val_r[15:8])
                             && (dir_idx_r[g] == val_r[7:0]);
      end
   endgenerate

   // Lowest matching slot wins; other-speed types need a high-speed part
   always_comb begin
      hit = 1'b0;
      hit_base = '0;
      hit_len = 16'h0000;
      for (int i = DIR_SLOTS - 1; i >= 0; i--) begin
         if (hit_vec[i]) begin
            hit = 1'b1;
            hit_base = dir_base_r[i];
            hit_len = dir_len_r[i];
         end
      end
      if (!HS_CAPABLE && (val_r[15:8] == srr_pkg::DT_QUALIFIER
                          || val_r[15:8] == srr_pkg::DT_OTHER_SPEED)) begin
         hit = 1'b0;
      end
   end

   assign ep_num = idx_r[srr_pkg::EP_NUM_LSB +: srr_pkg::EP_NUM_W];
   assign ep_ok = (32'(ep_num) < NUM_EP) && (idx_r[6:4] == 3'h0) && (idx_r[15:8] == 8'h00);

   // Request decode; anything not accepted below is a request error
   always_comb begin
      dec_err = 1'b1;
      dec_desc = 1'b0;
      dec_byte_mode = 1'b0;
      dec_byte = 8'h00;
      clr_rw = 1'b0;
      clr_halt = 1'b0;
      case (rq_r)
         srr_pkg::REQ_CLEAR_FEATURE: begin
            // Default state is treated as unsupported
            if (dstate_r != srr_pkg::DST_DEFAULT && len_r == srr_pkg::LEN_ZERO) begin
               if (rt_r == srr_pkg::RT_DEV_OUT) begin
                  // Test mode selector falls through to an error
                  if (val_r == srr_pkg::FS_REMOTE_WAKEUP && RWAKE_SUPPORT) begin
                     dec_err = 1'b0;
                     clr_rw = 1'b1;
                  end
               end else if (rt_r == srr_pkg::RT_EP_OUT) begin
                  // Address state reaches endpoint zero only
                  if (val_r == srr_pkg::FS_ENDPOINT_HALT && ep_ok
                      && (dstate_r == srr_pkg::DST_CONFIGURED || ep_num == '0)) begin
                     dec_err = 1'b0;
                     clr_halt = 1'b1;
                  end
               end
               // Interfaces have no clearable features, so always an error
            end
         end
         srr_pkg::REQ_GET_CONFIGURATION: begin
            if (rt_r == srr_pkg::RT_DEV_IN && len_r == srr_pkg::LEN_ONE) begin
               dec_err = 1'b0;
               dec_byte_mode = 1'b1;
               // Zero unless configured
               dec_byte = (dstate_r == srr_pkg::DST_CONFIGURED) ? cfg_r : 8'h00;
            end
         end
         srr_pkg::REQ_GET_DESCRIPTOR: begin
            // No state check: valid in every state
            if (rt_r == srr_pkg::RT_DEV_IN && hit) begin
               dec_err = 1'b0;
               dec_desc = 1'b1;
            end
         end
         srr_pkg::REQ_GET_INTERFACE: begin
            if (rt_r == srr_pkg::RT_IF_IN && dstate_r == srr_pkg::DST_CONFIGURED
                && 32'(idx_r) < NUM_IF && len_r == srr_pkg::LEN_ONE) begin
               dec_err = 1'b0;
               dec_byte_mode = 1'b1;
               dec_byte = ALT_SETTING_I[idx_r[7:0]*8 +: 8];
            end
         end
         default: begin
            dec_err = 1'b1;
         end
      endcase
   end

   assign link.setup_ready = (fsm_r == srr_pkg::DV_IDLE);
   assign push = (fsm_r == srr_pkg::DV_STREAM) && (fcnt_r != 2'd2);
   assign pop = link.data_valid && link.data_ready;

   // Request sequencer
   always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         fsm_r <= srr_pkg::DV_IDLE;
         rt_r <= 8'h00;
         rq_r <= 8'h00;
         val_r <= 16'h0000;
         idx_r <= 16'h0000;
         len_r <= 16'h0000;
         cnt_r <= 16'h0000;
         ptr_r <= '0;
         use_byte_r <= 1'b0;
         byte_r <= 8'h00;
         stall_r <= 1'b0;
         short_r <= 1'b0;
      end else if (CE_I) begin
         case (fsm_r)
            srr_pkg::DV_IDLE: begin
               if (link.setup_valid) begin
                  rt_r <= link.rtype;
                  rq_r <= link.code;
                  val_r <= link.value;
                  idx_r <= link.index;
                  len_r <= link.length;
                  fsm_r <= srr_pkg::DV_DECODE;
               end
            end
            srr_pkg::DV_DECODE: begin
               stall_r <= dec_err;
               use_byte_r <= dec_byte_mode;
               byte_r <= dec_byte;
               ptr_r <= hit_base;
               // Send the lesser of stored and requested length
               cnt_r <= dec_byte_mode ? srr_pkg::LEN_ONE : (hit_len < len_r ? hit_len : len_r);
               // Short stored data ending on a full packet needs a zero-length packet
               short_r <= dec_desc && hit_len < len_r && (32'(hit_len) % MAX_PKT == 0);
               // Errors skip the data stage and stall at once
               if (dec_err || (dec_desc && (hit_len == 16'h0000 || len_r == 16'h0000))) begin
                  fsm_r <= srr_pkg::DV_CMPL;
               end else if (dec_desc || dec_byte_mode) begin
                  fsm_r <= srr_pkg::DV_STREAM;
               end else begin
                  fsm_r <= srr_pkg::DV_CMPL;
               end
            end
            srr_pkg::DV_STREAM: begin
               // Bytes leave in stored order, so nested descriptors keep their layout
               if (push) begin
                  ptr_r <= ptr_r + 1'b1;
                  cnt_r <= cnt_r - 16'h0001;
                  if (cnt_r == 16'h0001) begin
                     fsm_r <= srr_pkg::DV_FLUSH;
                  end
               end
            end
            srr_pkg::DV_FLUSH: begin
               // Completion waits until the host has taken every byte
               if (fcnt_r == 2'd0) begin
                  fsm_r <= srr_pkg::DV_CMPL;
               end
            end
            srr_pkg::DV_CMPL: begin
               fsm_r <= srr_pkg::DV_IDLE;
            end
            default: begin
               fsm_r <= srr_pkg::DV_IDLE;
            end
         endcase
      end
   end

   assign link.cmpl_valid = (fsm_r == srr_pkg::DV_CMPL);
   assign link.cmpl_stall = stall_r;
   assign link.cmpl_short = short_r;

   // Feature clear pulses land before the status stage can complete
   always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         CLR_REMOTE_WAKEUP_O <= 1'b0;
         CLR_HALT_O <= 1'b0;
         CLR_HALT_EP_O <= '0;
         CLR_HALT_IN_O <= 1'b0;
      end else if (CE_I) begin
         CLR_REMOTE_WAKEUP_O <= (fsm_r == srr_pkg::DV_DECODE) && clr_rw;
         CLR_HALT_O <= (fsm_r == srr_pkg::DV_DECODE) && clr_halt;
         if (fsm_r == srr_pkg::DV_DECODE && clr_halt) begin
            CLR_HALT_EP_O <= ep_num;
            CLR_HALT_IN_O <= idx_r[srr_pkg::EP_DIR_BIT];
         end
      end
   end

   // Two-entry buffer: a host stall holds data without losing a byte
   always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         fcnt_r <= 2'd0;
         buf_r[0] <= 9'h000;
         buf_r[1] <= 9'h000;
      end else if (CE_I) begin
         if (push) begin
            buf_r[wp_r] <= {cnt_r == 16'h0001, use_byte_r ? byte_r : mem[ptr_r]};
            wp_r <= ~wp_r;
         end
         if (pop) begin
            rp_r <= ~rp_r;
         end
         fcnt_r <= fcnt_r + {1'b0, push} - {1'b0, pop};
      end
   end

   assign link.data_valid = (fcnt_r != 2'd0);
   assign link.data = buf_r[rp_r][7:0];
   assign link.data_last = buf_r[rp_r][8];
endmodule : srr_device
`default_nettype wire

/* File: hw/srr_host.sv */
// Host end: issues requests and collects answers
`timescale 1ns/1ps
`default_nettype none
module srr_host (
   // Clock, reset, enable
   input wire logic CLOCK_I,
   input wire logic RESET_N_I,
   input wire logic CE_I,
   // Request from the user
   input wire logic REQ_VALID_I,
   output logic REQ_READY_O,
   input wire logic [7:0] REQ_TYPE_I,
   input wire logic [7:0] REQ_CODE_I,
   input wire logic [15:0] REQ_VALUE_I,
   input wire logic [15:0] REQ_INDEX_I,
   input wire logic [15:0] REQ_LENGTH_I,
   output logic REQ_BAD_O,
   // Answer bytes
   output logic RX_VALID_O,
   input wire logic RX_READY_I,
   output logic [7:0] RX_DATA_O,
   output logic RX_LAST_O,
   // Completion
   output logic DONE_O,
   output logic DONE_STALL_O,
   output logic DONE_SHORT_O,
   // Link to the device end
   srr_link_if.host link
);
   srr_pkg::srr_host_fsm_t fsm_r;
   logic legal;

   // Refuse requests the host side must never send
   always_comb begin
      legal = 1'b1;
      if (REQ_CODE_I == srr_pkg::REQ_CLEAR_FEATURE) begin
         // Selector must fit the recipient
         case (REQ_TYPE_I)
            srr_pkg::RT_DEV_OUT: legal = (REQ_VALUE_I == srr_pkg::FS_REMOTE_WAKEUP)
                                         || (REQ_VALUE_I == srr_pkg::FS_TEST_MODE);
            srr_pkg::RT_EP_OUT: legal = (REQ_VALUE_I == srr_pkg::FS_ENDPOINT_HALT);
            default: legal = 1'b0;
         endcase
      end else if (REQ_CODE_I == srr_pkg::REQ_GET_DESCRIPTOR) begin
         if (REQ_VALUE_I[15:8] != srr_pkg::DT_CONFIG && REQ_VALUE_I[15:8] != srr_pkg::DT_STRING
             && REQ_VALUE_I[7:0] != 8'h00) begin
            legal = 1'b0;
         end
         if (REQ_VALUE_I[15:8] != srr_pkg::DT_STRING && REQ_INDEX_I != 16'h0000) begin
            legal = 1'b0;
         end
      end
   end

   assign REQ_READY_O = (fsm_r == srr_pkg::HS_IDLE);
   assign link.setup_valid = (fsm_r == srr_pkg::HS_SETUP);
   // Holding register stalls the device buffer when the user stalls
   assign link.data_ready = !RX_VALID_O || RX_READY_I;

   always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         fsm_r <= srr_pkg::HS_IDLE;
         link.rtype <= 8'h00;
         link.code <= 8'h00;
         link.value <= 16'h0000;
         link.index <= 16'h0000;
         link.length <= 16'h0000;
         REQ_BAD_O <= 1'b0;
         DONE_O <= 1'b0;
         DONE_STALL_O <= 1'b0;
         DONE_SHORT_O <= 1'b0;
      end else if (CE_I) begin
         REQ_BAD_O <= 1'b0;
         DONE_O <= 1'b0;
         case (fsm_r)
            srr_pkg::HS_IDLE: begin
               if (REQ_VALID_I && !legal) begin
                  REQ_BAD_O <= 1'b1;
               end else if (REQ_VALID_I) begin
                  link.rtype <= REQ_TYPE_I;
                  link.code <= REQ_CODE_I;
                  link.value <= REQ_VALUE_I;
                  link.index <= REQ_INDEX_I;
                  link.length <= REQ_LENGTH_I;
                  fsm_r <= srr_pkg::HS_SETUP;
               end
            end
            srr_pkg::HS_SETUP: begin
               if (link.setup_ready) begin
                  fsm_r <= srr_pkg::HS_WAIT;
               end
            end
            srr_pkg::HS_WAIT: begin
               if (link.cmpl_valid) begin
                  DONE_O <= 1'b1;
                  DONE_STALL_O <= link.cmpl_stall;
                  DONE_SHORT_O <= link.cmpl_short;
                  fsm_r <= srr_pkg::HS_IDLE;
               end
            end
            default: begin
               fsm_r <= srr_pkg::HS_IDLE;
            end
         endcase
      end
   end

   // Answer byte holding register
   always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         RX_VALID_O <= 1'b0;
         RX_DATA_O <= 8'h00;
         RX_LAST_O <= 1'b0;
      end else if (CE_I) begin
         if (link.data_valid && link.data_ready) begin
            RX_VALID_O <= 1'b1;
            RX_DATA_O <= link.data;
            RX_LAST_O <= link.data_last;
         end else if (RX_READY_I) begin
            RX_VALID_O <= 1'b0;
         end
      end
   end
endmodule : srr_host
`default_nettype wire

/* File: tb/srr_link_asserts.sv */
// Checker on the link between the two ends
`timescale 1ns/1ps
`default_nettype none
module srr_link_asserts (
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RESET_N_I,
   // Setup
   input wire logic setup_valid,
   input wire logic setup_ready,
   input wire logic [7:0] rtype,
   input wire logic [7:0] code,
   input wire logic [15:0] value,
   input wire logic [15:0] length,
   // Data and completion
   input wire logic data_valid,
   input wire logic data_ready,
   input wire logic [7:0] data,
   input wire logic data_last,
   input wire logic cmpl_valid,
   input wire logic cmpl_stall,
   input wire logic cmpl_short
);
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic go;
   assign go = setup_valid && setup_ready;
   assign cnt_nxt = go ? 16'h0000 : cnt_r + {15'h0000, data_valid && data_ready};
   always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         cnt_r <= 16'h0000;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RESET_N_I);
   a_data_hold: assert property (data_valid && !data_ready |=>
      data_valid && $stable(data) && $stable(data_last)) else $error("byte dropped");
   a_byte_bound: assert property (data_valid |-> cnt_r < length)
      else $error("too many bytes");
   a_single_byte: assert property (data_valid && (code == 8'h08 || code == 8'h0a)
      |-> data_last && cnt_r == 16'h0000) else $error("answer not one byte");
   a_clear_nodata: assert property (code == 8'h01 |-> !data_valid)
      else $error("data on clear");
   a_test_stall: assert property (go && code == 8'h01 && rtype == 8'h00
      && value == 16'h0002 |-> ##[1:4] cmpl_valid && cmpl_stall) else $error("test mode kept");
   a_stall_early: assert property (cmpl_valid && cmpl_stall |-> cnt_r == 16'h0000)
      else $error("late stall");
   a_short_flag: assert property (cmpl_valid && cmpl_short |-> !cmpl_stall
      && cnt_r < length && cnt_r[2:0] == 3'h0) else $error("bad short flag");
   a_cmpl_idle: assert property (cmpl_valid |-> !data_valid ##1 !cmpl_valid)
      else $error("completion amid data");
   a_setup_busy: assert property (go |=> !setup_ready && !cmpl_valid)
      else $error("setup taken twice");
endmodule : srr_link_asserts
`default_nettype wire

/* File: tb/tb_top.sv */
// Testbench joining host end and device end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, rv = 1'b0, rr = 1'b0, adr = 1'b0;
   logic [7:0] rt = 8'h00, rc = 8'h00, cfg = 8'h00, alt = 8'h00, lf = 8'h33;
   logic [15:0] val = 16'h0000, idx = 16'h0000, len = 16'h0000, dl = 16'h0000;
   logic dwe = 1'b0, we = 1'b0, ce = 1'b1;
   logic [7:0] da = 8'h00, dd = 8'h00, dt = 8'h00, db = 8'h00;
   logic [1:0] ds = 2'b00, st;
   logic rdy, bad, rxv, rxl, dn, dns, dnh, cw, ch, ci;
   logic [7:0] rxd;
   logic [3:0] cep;
   logic [7:0] mem [0:31];
   int fail_count = 0;
   int checks = 0;
   srr_link_if lk();
   srr_device srr_device_i (.CLOCK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .link(lk.dev),
      .DEV_ADDRESSED_I(adr), .CONFIG_VALUE_I(cfg), .ALT_SETTING_I(alt), .DESC_WE_I(dwe),
      .DESC_ADDR_I(da), .DESC_DATA_I(dd), .DIR_WE_I(we), .DIR_SEL_I(ds), .DIR_TYPE_I(dt),
      .DIR_INDEX_I(8'h00), .DIR_BASE_I(db), .DIR_LEN_I(dl), .CLR_REMOTE_WAKEUP_O(cw),
      .CLR_HALT_O(ch), .CLR_HALT_EP_O(cep), .CLR_HALT_IN_O(ci), .DEV_STATE_O(st));
   srr_host srr_host_i (.CLOCK_I(clk), .RESET_N_I(rst_n), .CE_I(ce), .REQ_VALID_I(rv),
      .REQ_READY_O(rdy), .REQ_TYPE_I(rt), .REQ_CODE_I(rc), .REQ_VALUE_I(val),
      .REQ_INDEX_I(idx), .REQ_LENGTH_I(len), .REQ_BAD_O(bad), .RX_VALID_O(rxv),
      .RX_READY_I(rr), .RX_DATA_O(rxd), .RX_LAST_O(rxl), .DONE_O(dn), .DONE_STALL_O(dns),
      .DONE_SHORT_O(dnh), .link(lk.host));
   srr_link_asserts chk_i (.CLOCK_I(clk), .RESET_N_I(rst_n), .setup_valid(lk.setup_valid),
      .setup_ready(lk.setup_ready), .rtype(lk.rtype), .code(lk.code), .value(lk.value),
      .length(lk.length), .data_valid(lk.data_valid), .data_ready(lk.data_ready),
      .data(lk.data), .data_last(lk.data_last), .cmpl_valid(lk.cmpl_valid),
      .cmpl_stall(lk.cmpl_stall), .cmpl_short(lk.cmpl_short));
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction : lfsr
   // Bytes expected: none on error or clear, one for a value, else truncated
   function automatic int want(input logic s, input logic [7:0] c, input int sz, input int l);
      if (s || c == 8'h01) return 0;
      if (sz == 0) return 1;
      return (sz < l) ? sz : l;
   endfunction : want
   task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk_val
   task automatic wrap_up();
      $display("errors %0d checks %0d", fail_count, checks);
      if (fail_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // Random stall by the receiver; not a known weakness, a pressure on the buffer
   always #20 clk = ~clk;
   always @(posedge clk) begin
      lf <= lfsr(lf);
      rr <= lf[0] | lf[3];
   end
   task automatic xf(input logic [7:0] t, c, input logic [15:0] v, i, l,
         input logic s, h, input logic [7:0] b0, b, input int sz);
      int n;
      int k;
      bit seen;
      n = 0;
      k = 0;
      seen = 0;
      @(posedge clk);
      rv <= 1'b1;
      rt <= t;
      rc <= c;
      val <= v;
      idx <= i;
      len <= l;
      @(posedge clk);
      rv <= 1'b0;
      for (int w = 0; w < 300 && !(seen && !rxv); w++) begin
         @(negedge clk);
         if (rxv && rr) begin
            chk_val({8'h00, rxd}, {8'h00, (sz == 0) ? b0 : mem[b + n]});
            chk_val(16'(rxl), 16'(n == want(s, c, sz, l) - 1));
            n++;
         end
         k += int'(ch | cw);
         if (dn) begin
            seen = 1;
            chk_val({dns, dnh}, {s, h});
         end
      end
      chk_val(16'(n), 16'(want(s, c, sz, l)));
      chk_val(16'(k) + 16'(seen), 16'(!s && c == 8'h01) + 16'h0001);
      // Return on a rising edge so the caller drives inputs there
      @(posedge clk);
   endtask : xf
   // Refused requests pulse the refusal flag once and never leave idle
   task automatic refuse(input logic [7:0] t, c, input logic [15:0] v, i);
      int b;
      b = 0;
      @(posedge clk);
      rv <= 1'b1;
      rt <= t;
      rc <= c;
      val <= v;
      idx <= i;
      @(posedge clk);
      rv <= 1'b0;
      repeat (3) begin
         @(negedge clk);
         b += int'(bad) + 2 * int'(!rdy);
      end
      @(posedge clk);
      chk_val(16'(b), 16'h0001);
   endtask : refuse
   initial begin
      #2000000;
      fail_count++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 32; a++) begin
         @(posedge clk);
         dwe <= 1'b1;
         da <= 8'(a);
         dd <= lf;
         mem[a] = lf;
      end
      @(posedge clk);
      dwe <= 1'b0;
      we <= 1'b1;
      dt <= srr_pkg::DT_DEVICE;
      dl <= 16'h0008;
      @(posedge clk);
      ds <= 2'b01;
      dt <= srr_pkg::DT_CONFIG;
      db <= 8'h10;
      dl <= 16'h000c;
      @(posedge clk);
      we <= 1'b0;
      refuse(8'h02, 8'h01, 16'h0001, 16'h0000);
      refuse(8'h80, 8'h06, 16'h0101, 16'h0000);
      refuse(8'h80, 8'h06, 16'h0100, 16'h0409);
      xf(8'h80, 8'h06, 16'h0100, 0, 16'h0040, 0, 1, 0, 0, 8);
      xf(8'h80, 8'h06, 16'h0100, 0, 16'h0003, 0, 0, 0, 0, 8);
      xf(8'h80, 8'h06, 16'h0200, 0, 16'h00ff, 0, 0, 0, 8'h10, 12);
      xf(8'h80, 8'h06, 16'h0600, 0, 16'h0040, 1, 0, 0, 0, 0);
      xf(8'h80, 8'h08, 0, 0, 16'h0001, 0, 0, 8'h00, 0, 0);
      chk_val(16'(st), 16'(srr_pkg::DST_DEFAULT));
      // Enable low must freeze the state even though the address arrives
      ce <= 1'b0;
      adr <= 1'b1;
      repeat (3) @(posedge clk);
      chk_val(16'(st), 16'(srr_pkg::DST_DEFAULT));
      ce <= 1'b1;
      xf(8'h80, 8'h08, 0, 0, 16'h0001, 0, 0, 8'h00, 0, 0);
      chk_val(16'(st), 16'(srr_pkg::DST_ADDRESS));
      xf(8'h81, 8'h0a, 0, 0, 16'h0001, 1, 0, 0, 0, 0);
      xf(8'h02, 8'h01, 0, 16'h0001, 0, 1, 0, 0, 0, 0);
      xf(8'h02, 8'h01, 0, 16'h0080, 0, 0, 0, 0, 0, 0);
      chk_val(16'(ci), 16'h0001);
      chk_val(16'(cep), 16'h0000);
      cfg <= lf | 8'h01;
      alt <= lf;
      xf(8'h80, 8'h08, 0, 0, 16'h0001, 0, 0, lf | 8'h01, 0, 0);
      chk_val(16'(st), 16'(srr_pkg::DST_CONFIGURED));
      xf(8'h81, 8'h0a, 0, 0, 16'h0001, 0, 0, alt, 0, 0);
      xf(8'h81, 8'h0a, 0, 16'h0001, 16'h0001, 1, 0, 0, 0, 0);
      xf(8'h02, 8'h01, 0, 16'h0001, 0, 0, 0, 0, 0, 0);
      chk_val(16'(cep), 16'h0001);
      chk_val(16'(ci), 16'h0000);
      xf(8'h02, 8'h01, 0, 16'h0002, 0, 1, 0, 0, 0, 0);
      xf(8'h00, 8'h01, 16'h0001, 0, 0, 0, 0, 0, 0, 0);
      xf(8'h00, 8'h01, 16'h0002, 0, 0, 1, 0, 0, 0, 0);
      xf(8'h80, 8'h06, 16'h0200, 0, 16'(lf[3:0]), 0, 0, 0, 8'h10, 12);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
